// ---- pkg/sauw_pkg.sv ----
// Constants for the secondary arbiter and upstream window configuration.
package sauw_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_ARB = 8'h40;
  localparam logic [7:0] OFS_CHIP = 8'h48;
  localparam logic [7:0] OFS_PRE = 8'h4C;
  localparam logic [7:0] OFS_WIN = 8'h50;
  localparam logic [7:0] OFS_BASE_HI = 8'h54;
  localparam logic [7:0] OFS_LIM_HI = 8'h58;
  // Field positions.
  localparam int PRIO_LSB = 16;
  localparam int BRIDGE_PRIO_BIT = 25;
  localparam int FT_BIT = 0;
  localparam int PARK_BIT = 1;
  localparam int WIN_EN_BIT = 16;
  localparam int PRE_LSB = 28;
  localparam int CAP_BASE_LSB = 0;
  localparam int BASE_LSB = 4;
  localparam int CAP_LIM_LSB = 16;
  localparam int LIM_LSB = 20;
  // Values after reset.
  localparam logic [8:0] PRIO_RST = 9'h000;
  localparam logic BRIDGE_PRIO_RST = 1'b1;
  localparam logic FT_RST = 1'b0;
  localparam logic PARK_RST = 1'b0;
  localparam logic WIN_EN_RST = 1'b0;
  localparam logic [3:0] PRE_RST = 4'h0;
  localparam logic [11:0] BASE_RST = 12'h000;
  localparam logic [11:0] LIM_RST = 12'h000;
  localparam logic [31:0] HI_RST = 32'h00000000;
  // Read-only capability code: 64-bit addressing supported.
  localparam logic [3:0] CAP_64 = 4'h1;
  // Low address bits implied by the base and the limit fields.
  localparam logic [19:0] BASE_FILL = 20'h00000;
  localparam logic [19:0] LIM_FILL = 20'hFFFFF;
  // Preemption delay counter: width and saturation value (64 clocks).
  localparam int PRE_CNT_W = 7;
  localparam logic [6:0] PRE_CNT_MAX = 7'h40;
endpackage

// ---- verilog/sauw_arb.sv ----
// Grant logic of the secondary bus arbiter: two groups, round robin, park.
`timescale 1ns/100ps
module sauw_arb import sauw_pkg::*; #(
  parameter int N = 10
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset_n,
  // Requests, active high; entry N-1 is the bridge itself.
  input wire logic [N-1:0] req,
  input wire logic [N-1:0] high_grp,
  // Park policy from the register bank; bus busy and preemption window from the top level.
  input wire logic park_to_bridge,
  input wire logic bus_busy,
  input wire logic preempt_ok,
  // One-hot grant.
  output logic [N-1:0] gnt
);
  localparam int IW = $clog2(N);

  logic [N-1:0] gnt_q;
  logic [IW-1:0] last_q;
  logic [N-1:0] hi_req;
  logic [N-1:0] lo_req;
  logic [IW-1:0] winner;
  logic allow;

  // Round-robin search starting just after the last granted entry.
  function automatic logic [IW-1:0] rr_pick(input logic [N-1:0] v,
                                            input logic [IW-1:0] start);
    int k;
    logic found;
    begin
      rr_pick = start;
      found = 1'b0;
      for (int i = 1; i <= N; i++) begin
        k = int'(start) + i;
        if (k >= N) begin
          k = k - N;
        end
        if (!found && v[k]) begin
          rr_pick = IW'(k);
          found = 1'b1;
        end
      end
    end
  endfunction

  // High group is always served first; low group only when high is empty.
  assign hi_req = req & high_grp;
  assign lo_req = req & ~high_grp;
  assign winner = (|hi_req) ? rr_pick(hi_req, last_q)
                            : rr_pick(lo_req, last_q);
  // The grant may only move while the bus is idle or preemption is open.
  assign allow = !bus_busy || preempt_ok;
  assign gnt = gnt_q;

  // Grant register and last-master memory.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      gnt_q <= '0;
      last_q <= IW'(N - 1);
    end else if (allow) begin
      if (|req) begin
        gnt_q <= N'(1) << winner;
        last_q <= winner;
      end else if (park_to_bridge) begin
        gnt_q <= N'(1) << (N - 1);
      end else begin
        gnt_q <= N'(1) << last_q;
      end
    end
  end
endmodule // sauw_arb

// ---- verilog/sauw_top.sv ----
// Secondary arbiter and upstream window configuration bank with its logic.
//
// Overview of operation
// - Nine writable master priority bits, reset zero.
// - Bit 24 is request 8, bit 16 request 0.
// - Bridge priority bit, resets high group.
// - Reserved bits read zero, ignore writes.
// - Memory read flow-through only when enabled.
// - Idle bus parks on last master or bridge.
// - Window enable confines upstream claims to range.
// - Four-bit preemption delay; top bit disables.
// - Codes zero to seven give 0..64 clocks.
// - Both window registers report 64-bit capability.
// - Writable upper base address field, reset zero.
// - Writable upper limit address field.
// - Base bits 63 to 32 register, reset zero.
// - Limit bits 63 to 32 register, reset zero.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module sauw_top import sauw_pkg::*; #(
  parameter int NREQ = 9
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset_n,
  // Avalon-MM slave.
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Secondary bus arbitration pins.
  input wire logic [NREQ-1:0] sec_req_n,
  input wire logic sec_frame_n,
  output logic [NREQ-1:0] sec_gnt_n,
  // Bridge's own secondary master.
  input wire logic bridge_req,
  output logic bridge_gnt,
  // Forwarding datapath interface.
  input wire logic [63:0] fwd_addr,
  input wire logic fwd_in_downstream,
  output logic upstream_claim,
  output logic flow_through_en
);
  localparam int NA = NREQ + 1;

  // Configuration state.
  logic [NREQ-1:0] prio_q;
  logic bridge_prio_q;
  logic ft_en_q;
  logic park_q;
  logic win_en_q;
  logic [3:0] pre_q;
  logic [11:0] base_q;
  logic [11:0] lim_q;
  logic [31:0] base_hi_q;
  logic [31:0] lim_hi_q;

  // Bus slave state.
  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [31:0] wmask;
  logic [31:0] cur_word;
  logic [31:0] wword;
  logic wr_fire;

  // Synchronised pins.
  logic [NREQ-1:0] req_n_meta_q;
  logic [NREQ-1:0] req_n_sync_q;
  logic frame_n_meta_q;
  logic frame_n_sync_q;

  // Preemption timing.
  logic [PRE_CNT_W-1:0] frame_cnt_q;
  logic [PRE_CNT_W-1:0] pre_delay;
  logic preempt_ok;
  logic bus_busy;

  // Arbiter vectors.
  logic [NA-1:0] arb_req;
  logic [NA-1:0] arb_high;
  logic [NA-1:0] arb_gnt;

  // Window compare.
  logic [63:0] win_base;
  logic [63:0] win_limit;
  logic in_window;
  logic upstream_claim_q;

  // One wait state: the request is taken on the edge where ack_q is high.
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign wr_fire = avs_write && ack_q;
  assign avs_readdata = rdata_q;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  // Read mux; unmapped offsets and reserved bits read as zero.
  always_comb begin
    rdata_d = 32'h00000000;
    case (avs_address)
      OFS_ARB: begin
        rdata_d[PRIO_LSB +: NREQ] = prio_q;
        rdata_d[BRIDGE_PRIO_BIT] = bridge_prio_q;
      end
      OFS_CHIP: begin
        rdata_d[FT_BIT] = ft_en_q;
        rdata_d[PARK_BIT] = park_q;
        rdata_d[WIN_EN_BIT] = win_en_q;
      end
      OFS_PRE: begin
        rdata_d[PRE_LSB +: 4] = pre_q;
      end
      OFS_WIN: begin
        rdata_d[CAP_BASE_LSB +: 4] = CAP_64;
        rdata_d[BASE_LSB +: 12] = base_q;
        rdata_d[CAP_LIM_LSB +: 4] = CAP_64;
        rdata_d[LIM_LSB +: 12] = lim_q;
      end
      OFS_BASE_HI: begin
        rdata_d = base_hi_q;
      end
      OFS_LIM_HI: begin
        rdata_d = lim_hi_q;
      end
      default: begin
        rdata_d = 32'h00000000;
      end
    endcase
  end

  // Read data is captured in the wait cycle so it stands at the answer.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 32'h00000000;
    end else if (avs_read && !ack_q) begin
      rdata_q <= rdata_d;
    end
  end

  // Byte enables pick which lanes of the current word are replaced.
  always_comb begin
    wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    cur_word = rdata_d;
    wword = (cur_word & ~wmask) | (avs_writedata & wmask);
  end

  // Arbiter priority register; only the defined bits are stored.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prio_q <= PRIO_RST;
      bridge_prio_q <= BRIDGE_PRIO_RST;
    end else if (wr_fire && avs_address == OFS_ARB) begin
      prio_q <= wword[PRIO_LSB +: NREQ];
      bridge_prio_q <= wword[BRIDGE_PRIO_BIT];
    end
  end

  // Chip control and window enable share one word.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ft_en_q <= FT_RST;
      park_q <= PARK_RST;
      win_en_q <= WIN_EN_RST;
    end else if (wr_fire && avs_address == OFS_CHIP) begin
      ft_en_q <= wword[FT_BIT];
      park_q <= wword[PARK_BIT];
      win_en_q <= wword[WIN_EN_BIT];
    end
  end

  // Preemption control field.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_q <= PRE_RST;
    end else if (wr_fire && avs_address == OFS_PRE) begin
      pre_q <= wword[PRE_LSB +: 4];
    end
  end

  // Upper base and limit fields; capability nibbles are not writable.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      base_q <= BASE_RST;
      lim_q <= LIM_RST;
    end else if (wr_fire && avs_address == OFS_WIN) begin
      base_q <= wword[BASE_LSB +: 12];
      lim_q <= wword[LIM_LSB +: 12];
    end
  end

  // High halves of the 64-bit base and limit.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      base_hi_q <= HI_RST;
      lim_hi_q <= HI_RST;
    end else if (wr_fire) begin
      if (avs_address == OFS_BASE_HI) begin
        base_hi_q <= wword;
      end
      if (avs_address == OFS_LIM_HI) begin
        lim_hi_q <= wword;
      end
    end
  end

  // Pins come from another clock, so each passes two flip-flops first.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_n_meta_q <= '1;
      req_n_sync_q <= '1;
      frame_n_meta_q <= 1'b1;
      frame_n_sync_q <= 1'b1;
    end else begin
      req_n_meta_q <= sec_req_n;
      req_n_sync_q <= req_n_meta_q;
      frame_n_meta_q <= sec_frame_n;
      frame_n_sync_q <= frame_n_meta_q;
    end
  end

  assign bus_busy = !frame_n_sync_q;

  // Clocks since frame assertion; saturates at the longest delay.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_cnt_q <= '0;
    end else if (!bus_busy) begin
      frame_cnt_q <= '0;
    end else if (frame_cnt_q != PRE_CNT_MAX) begin
      frame_cnt_q <= frame_cnt_q + PRE_CNT_W'(1);
    end
  end

  // Code zero means no wait; code n waits two to the n-1 clocks.
  always_comb begin
    if (pre_q[2:0] == 3'h0) begin
      pre_delay = '0;
    end else begin
      pre_delay = PRE_CNT_W'(1) << (pre_q[2:0] - 3'h1);
    end
  end

  // A set top bit closes preemption for good, whatever the count.
  assign preempt_ok = !pre_q[3] && (frame_cnt_q >= pre_delay);

  // Requests enter in pin order; the bridge is the top entry.
  assign arb_req = {bridge_req, ~req_n_sync_q};
  assign arb_high = {bridge_prio_q, prio_q};

  sauw_arb #(
    .N(NA)
  ) u_arb (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .req(arb_req),
    .high_grp(arb_high),
    .park_to_bridge(park_q),
    .bus_busy(bus_busy),
    .preempt_ok(preempt_ok),
    .gnt(arb_gnt)
  );

  assign sec_gnt_n = ~arb_gnt[NREQ-1:0];
  assign bridge_gnt = arb_gnt[NREQ];

  // The forwarding datapath may only flow reads through when enabled.
  assign flow_through_en = ft_en_q;

  // Window bounds: base is rounded down and limit up to 1 MB granules.
  assign win_base = {base_hi_q, base_q, BASE_FILL};
  assign win_limit = {lim_hi_q, lim_q, LIM_FILL};
  assign in_window = (fwd_addr >= win_base) &&
                     (fwd_addr <= win_limit);

  // Claim decision is registered, one clock after the address is shown.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      upstream_claim_q <= 1'b0;
    end else begin
      upstream_claim_q <= !fwd_in_downstream &&
                          (!win_en_q || in_window);
    end
  end

  assign upstream_claim = upstream_claim_q;
endmodule // sauw_top

// ---- bench/sauw_checker.sv ----
// Assertion checker for the arbiter and upstream window configuration bank.
`timescale 1ns/100ps
module sauw_checker import sauw_pkg::*; #(
  parameter int NREQ = 9
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register bus.
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Arbiter and window outputs.
  input wire logic [NREQ-1:0] sec_gnt_n,
  input wire logic bridge_gnt,
  input wire logic fwd_in_downstream,
  input wire logic upstream_claim,
  input wire logic flow_through_en
);
  // Accesses at the edge where the bus takes them.
  logic rd_take;
  logic wr_take;
  assign rd_take = avs_read && !avs_waitrequest;
  assign wr_take = avs_write && !avs_waitrequest;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // A waiting access is answered on the very next cycle.
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("wait state not one cycle");
  // Two grants at once would let two masters drive the bus.
  grant_onehot_a: assert property ($onehot0({~sec_gnt_n, bridge_gnt}))
    else $error("more than one grant");
  arb_rsvd_a: assert property (rd_take && avs_address == OFS_ARB |->
    avs_readdata[31:26] == 6'h00 && avs_readdata[15:0] == 16'h0000)
    else $error("arbiter reserved bits set");
  chip_rsvd_a: assert property (rd_take && avs_address == OFS_CHIP |->
    avs_readdata[31:17] == 15'h0000 && avs_readdata[15:2] == 14'h0000)
    else $error("chip control reserved bits set");
  pre_rsvd_a: assert property (rd_take && avs_address == OFS_PRE |->
    avs_readdata[27:0] == 28'h0000000) else $error("preempt reserved set");
  cap_ro_a: assert property (rd_take && avs_address == OFS_WIN |->
    avs_readdata[3:0] == CAP_64 && avs_readdata[19:16] == CAP_64)
    else $error("capability field wrong");
  ft_write_a: assert property (wr_take && avs_address == OFS_CHIP &&
    avs_byteenable[0] |=> flow_through_en == $past(avs_writedata[FT_BIT]))
    else $error("flow-through bit not written");
  claim_ds_a: assert property (fwd_in_downstream |=> !upstream_claim)
    else $error("downstream address claimed upstream");
  // Main scenarios reached.
  cov_read_c: cover property (rd_take);
  cov_write_c: cover property (wr_take);
  cov_park_c: cover property ($rose(bridge_gnt));
  cov_claim_c: cover property (upstream_claim);
endmodule // sauw_checker

bind sauw_top sauw_checker #(.NREQ(NREQ)) sauw_checker_i (
  .ref_clk(ref_clk),
  .reset_n(reset_n),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .sec_gnt_n(sec_gnt_n),
  .bridge_gnt(bridge_gnt),
  .fwd_in_downstream(fwd_in_downstream),
  .upstream_claim(upstream_claim),
  .flow_through_en(flow_through_en)
);

// ---- bench/sauw_masters.sv ----
// Behavioural model of the secondary bus masters competing for the bus.
`timescale 1ns/100ps
module sauw_masters #(
  parameter int N = 9,
  parameter int BURST = 90
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset_n,
  // Control from the bench and grants from the arbiter.
  input wire logic [N-1:0] want,
  input wire logic [N-1:0] gnt_n,
  // Bus pins and completion flags.
  output logic [N-1:0] req_n,
  output logic frame_n,
  output logic [N-1:0] done
);
  int left;
  int own;
  // A master keeps requesting until its one transaction is finished.
  assign req_n = ~(want & ~done);
  // Only a granted master on an idle bus may start; the frame is fixed long.
  // Grants are one-hot, so at most one master can start on a given edge.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_n <= 1'b1;
      done <= '0;
      left <= 0;
      own <= 0;
    end else begin
      done <= done & want;
      if (left > 1) begin
        left <= left - 1;
      end else if (left == 1) begin
        left <= 0;
        frame_n <= 1'b1;
        done[own] <= 1'b1;
      end else begin
        for (int i = 0; i < N; i++) begin
          if (frame_n && want[i] && !done[i] && !gnt_n[i]) begin
            own <= i;
            left <= BURST;
            frame_n <= 1'b0;
          end
        end
      end
    end
  end
endmodule // sauw_masters

// ---- bench/tb.sv ----
// Self-checking testbench for the arbiter and upstream window bank.
`timescale 1ns/100ps
module tb;
  import sauw_pkg::*;
  logic ref_clk = 0, reset_n = 0, avs_read = 0, avs_write = 0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0] avs_byteenable = 4'hF;
  logic avs_waitrequest, sec_frame_n, bridge_req = 0, bridge_gnt;
  logic [8:0] sec_req_n, sec_gnt_n, done, want = 9'h000;
  logic [63:0] fwd_addr = 64'h0;
  logic fwd_in_downstream = 0, upstream_claim, flow_through_en;
  int mismatches = 0, samples_checked = 0, cyc = 0, t, dly;
  logic [7:0] ra [7] = '{8'h40, 8'h44, 8'h48, 8'h4C, 8'h50, 8'h54, 8'h58};
  logic [31:0] rr [7] = '{32'h02000000, 0, 0, 0, 32'h00010001, 0, 0};
  logic [31:0] ro [7] = '{32'h03FF0000, 0, 32'h00010003, 32'hF0000000,
    32'hFFF1FFF1, 32'hFFFFFFFF, 32'hFFFFFFFF};
  logic [63:0] wa [7] = '{64'h000FFFFF, 64'h00100000, 64'h002FFFFF,
    64'h00300000, 64'h100100000, 64'h00200000, 64'h00300000};
  logic [6:0] wd = 7'h20, we = 7'h3F, wx = 7'h46;
  sauw_top sauw_top_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sec_req_n(sec_req_n), .sec_frame_n(sec_frame_n),
    .sec_gnt_n(sec_gnt_n), .bridge_req(bridge_req), .bridge_gnt(bridge_gnt),
    .fwd_addr(fwd_addr), .fwd_in_downstream(fwd_in_downstream),
    .upstream_claim(upstream_claim), .flow_through_en(flow_through_en));
  sauw_masters sauw_masters_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .want(want), .gnt_n(sec_gnt_n), .req_n(sec_req_n),
    .frame_n(sec_frame_n), .done(done));
  // Free-running 50 MHz clock.
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus access; the request stands until waitrequest is seen low.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic ewait(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Hang guard: the full sequence needs well under this many cycles.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      final_report;
    end
  end
  initial begin
    ewait(6);
    reset_n <= 1'b1;
    ewait(2);
    chk(flow_through_en, 0);
    // Reset values, then all ones written and masked by access kind.
    for (int i = 0; i < 7; i++) begin
      bus(0, ra[i], 0);
      chk(q, rr[i]);
      wr(ra[i], 32'hFFFFFFFF);
      bus(0, ra[i], 0);
      chk(q, ro[i]);
    end
    chk(flow_through_en, 1);
    // Master 1 holds a long frame while high-group master 2 asks.
    wr(OFS_CHIP, 0);
    wr(OFS_ARB, 32'h00040000);
    for (int c = 0; c < 9; c++) begin
      wr(OFS_PRE, {c[3:0], 28'h0});
      dly = (c == 0) ? 0 : (1 << (c - 1));
      want <= 9'h002;
      while (sec_frame_n !== 1'b0) @(posedge ref_clk);
      want <= 9'h006;
      t = 0;
      while (sec_gnt_n[1] === 1'b0 && t < 200) begin
        @(posedge ref_clk);
        t++;
      end
      chk((c > 7) ? (t >= 88) : (t >= dly && t <= dly + 8), 1);
      while (done !== 9'h006) @(posedge ref_clk);
      want <= 9'h000;
      ewait(2);
    end
    // Window from 0x00100000 to 0x002FFFFF, then unconfined.
    wr(OFS_WIN, 32'h00200010);
    wr(OFS_BASE_HI, 0);
    wr(OFS_LIM_HI, 0);
    for (int i = 0; i < 7; i++) begin
      wr(OFS_CHIP, {15'h0, we[i], 16'h0});
      fwd_addr <= wa[i];
      fwd_in_downstream <= wd[i];
      ewait(2);
      chk(upstream_claim, wx[i]);
    end
    // Park on the last master, then on the bridge.
    wr(OFS_CHIP, 0);
    want <= 9'h008;
    while (done[3] !== 1'b1) @(posedge ref_clk);
    want <= 9'h000;
    ewait(6);
    chk({sec_gnt_n[3], bridge_gnt}, 0);
    wr(OFS_CHIP, 2);
    ewait(6);
    chk({sec_gnt_n[3], bridge_gnt}, 3);
    // Requests 0 and 8 together; only the high-group one may win.
    for (int j = 0; j < 2; j++) begin
      wr(OFS_ARB, j ? 32'h01000000 : 32'h00010000);
      want <= 9'h101;
      while (sec_gnt_n[0] & sec_gnt_n[8]) @(posedge ref_clk);
      chk(sec_gnt_n[0], j);
      while (done !== 9'h101) @(posedge ref_clk);
      want <= 9'h000;
      ewait(6);
    end
    // Bridge against master 4 arriving together; the high group must win.
    wr(OFS_CHIP, 0);
    for (int j = 0; j < 2; j++) begin
      wr(OFS_ARB, j ? 32'h00100000 : 32'h02000000);
      want <= 9'h010;
      ewait(2);
      bridge_req <= 1'b1;
      ewait(2);
      chk({bridge_gnt, sec_gnt_n[4]}, j ? 0 : 3);
      bridge_req <= 1'b0;
      while (done[4] !== 1'b1) @(posedge ref_clk);
      want <= 9'h000;
      ewait(6);
    end
    final_report;
  end
endmodule // tb
